// [rtl/bccl_pkg.sv]
package bccl_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SPR_W = 10;
  localparam int unsigned IMM_W = 16;
  localparam int unsigned BI_W = 5;
  localparam int unsigned BO_W = 5;
  localparam int unsigned FIELD_W = 4;
  localparam int unsigned NUM_FIELDS = 8;
  localparam int unsigned FIELD_SEL_W = 3;

  // ----------------------------------------------------------------
  // special register numbers
  // ----------------------------------------------------------------
  localparam logic [9:0] SPR_LINK = 10'h008;
  localparam logic [9:0] SPR_COUNT = 10'h009;

  // ----------------------------------------------------------------
  // condition bit numbering
  // ----------------------------------------------------------------
  localparam logic [5:0] CR_ARCH_BASE = 6'h20;
  localparam logic [1:0] BIT_LT = 2'h0;
  localparam logic [1:0] BIT_GT = 2'h1;
  localparam logic [1:0] BIT_EQ = 2'h2;
  localparam logic [1:0] BIT_SO = 2'h3;

  // ----------------------------------------------------------------
  // branch options field, value bit positions
  // ----------------------------------------------------------------
  localparam int unsigned BO_IGN_COND = 4;
  localparam int unsigned BO_COND_VAL = 3;
  localparam int unsigned BO_NO_DEC = 2;
  localparam int unsigned BO_CTR_ZERO = 1;

  // ----------------------------------------------------------------
  // misc values
  // ----------------------------------------------------------------
  localparam int unsigned ALIGN_BITS = 2;
  localparam logic [31:0] WORD_ALIGN_MASK = 32'hFFFF_FFFC;
  localparam logic [31:0] COUNT_STEP = 32'h0000_0001;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

  // ----------------------------------------------------------------
  // branch kinds
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    BCCL_BR_REL,
    BCCL_BR_COUNT,
    BCCL_BR_LINK
  } bccl_br_kind_e;

endpackage

// [rtl/bccl_cmp.sv]
`timescale 1ns/1ps
`default_nettype none

module bccl_cmp #(
  parameter int unsigned W = 32
) (
  input wire logic [W-1:0] op_a,
  input wire logic [W-1:0] op_b,
  input wire logic is_signed,
  output logic lt,
  output logic gt,
  output logic eq
);

  // ----------------------------------------------------------------
  // signed or unsigned magnitude compare
  // ----------------------------------------------------------------
  always_comb
  begin
    eq = (op_a == op_b);
    if (is_signed)
    begin
      lt = ($signed(op_a) < $signed(op_b));
    end
    else
    begin
      lt = (op_a < op_b);
    end
    gt = !lt && !eq;
  end

endmodule

`default_nettype wire

// [rtl/bccl_bitsel.sv]
`timescale 1ns/1ps
`default_nettype none

module bccl_bitsel (
  input wire logic [4:0] bit_select,
  output logic [2:0] field,
  output logic [1:0] bit_in_field,
  output logic [5:0] arch_bit,
  output logic [4:0] vec_index
);

  // ----------------------------------------------------------------
  // field and bit split, architectural number
  // ----------------------------------------------------------------
  always_comb
  begin
    field = bit_select[4:2];
    bit_in_field = bit_select[1:0];
    arch_bit = bccl_pkg::CR_ARCH_BASE + {1'b0, bit_select};
    vec_index = ~bit_select;
  end

endmodule

`default_nettype wire

// [rtl/bccl_regs.sv]
// Behaviour
// - store-conditional completion updates condition field zero with its outcome
// - compare writes only the selected 4-bit field, others unchanged
// - bit b of field n is architectural bit 32+4n+b; select splits 3+2
// - compare sets less, greater or equal bit, signed or unsigned
// - fourth bit of compared field takes summary overflow at completion
// - branch options may decrement loop count and test new value
// - decrementing zero loop count leaves all ones
// - branch to count uses entire loop count as target
// - loop count is 32-bit read/write special register number 9
// - loop count and link undefined at power-on, kept across core reset
// - branch to link takes target from link register
// - branch with link option writes return address into link register, except a branch to count that also asks to decrement
// - branch to link ignores two low link bits, target word aligned
// - move-from special register 8 returns link register value
// - move-to special register 8 loads link register from general register
`timescale 1ns/1ps
`default_nettype none

module bccl_regs #(
  parameter int unsigned DATA_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic summary_overflow_flag,
  input wire logic stcx_done,
  input wire logic stcx_success,
  input wire logic cmp_valid,
  input wire logic [2:0] cmp_field,
  input wire logic cmp_signed,
  input wire logic cmp_use_imm,
  input wire logic [DATA_W-1:0] cmp_op_a,
  input wire logic [DATA_W-1:0] cmp_op_b,
  input wire logic [15:0] cmp_imm,
  input wire logic branch_valid,
  input wire bccl_pkg::bccl_br_kind_e branch_kind,
  input wire logic [4:0] branch_options_field,
  input wire logic [4:0] condition_bit_select,
  input wire logic branch_link,
  input wire logic [DATA_W-1:0] branch_rel_target,
  input wire logic [DATA_W-1:0] branch_return_addr,
  input wire logic spr_wr,
  input wire logic spr_rd,
  input wire logic [9:0] special_register_number,
  input wire logic [DATA_W-1:0] spr_wdata,
  output logic [DATA_W-1:0] spr_rdata_r,
  output logic spr_rd_valid_r,
  output logic spr_rd_hit_r,
  output logic branch_done_r,
  output logic branch_taken_r,
  output logic [DATA_W-1:0] branch_target_r,
  output logic branch_form_bad_r,
  output logic [5:0] branch_arch_bit_r,
  output logic branch_cond_bit_r,
  output logic [31:0] condition_flags_reg,
  output logic [DATA_W-1:0] loop_count,
  output logic [DATA_W-1:0] return_link_address
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] cr_r;
  logic [31:0] cr_nxt;
  logic [DATA_W-1:0] loop_count_r;
  logic [DATA_W-1:0] loop_count_nxt;
  logic [DATA_W-1:0] link_r;
  logic [DATA_W-1:0] link_nxt;

  // ----------------------------------------------------------------
  // compare operands and result
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] imm_ext;
  logic [DATA_W-1:0] cmp_b_sel;
  logic cmp_lt;
  logic cmp_gt;
  logic cmp_eq;
  logic [3:0] cmp_nib;
  logic [3:0] stcx_nib;

  always_comb
  begin
    if (cmp_signed)
    begin
      imm_ext = {{(DATA_W - 16){cmp_imm[15]}}, cmp_imm};
    end
    else
    begin
      imm_ext = {{(DATA_W - 16){1'b0}}, cmp_imm};
    end
    cmp_b_sel = cmp_use_imm ? imm_ext : cmp_op_b;
  end

  bccl_cmp #(
    .W(DATA_W)
  ) u_cmp (
    .op_a(cmp_op_a),
    .op_b(cmp_b_sel),
    .is_signed(cmp_signed),
    .lt(cmp_lt),
    .gt(cmp_gt),
    .eq(cmp_eq)
  );

  // field nibble holds lt, gt, eq, so from msb down
  always_comb
  begin
    cmp_nib = {cmp_lt, cmp_gt, cmp_eq, summary_overflow_flag};
    stcx_nib = {1'b0, 1'b0, stcx_success, summary_overflow_flag};
  end

  // ----------------------------------------------------------------
  // condition field update, one slice per field
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g++)
    begin : gen_field
      logic [3:0] field_nxt;
      always_comb
      begin
        field_nxt = cr_r[31 - 4*g -: 4];
        if (cmp_valid && (cmp_field == 3'(g)))
        begin
          field_nxt = cmp_nib;
        end
        if (stcx_done && (g == 0))
        begin
          field_nxt = stcx_nib;
        end
      end
      assign cr_nxt[31 - 4*g -: 4] = field_nxt;
    end
  endgenerate

  always_ff @(posedge sys_clk)
  begin
    cr_r <= cr_nxt;
  end

  // ----------------------------------------------------------------
  // branch condition evaluation
  // ----------------------------------------------------------------
  logic [2:0] bi_field;
  logic [1:0] bi_bit;
  logic [5:0] bi_arch;
  logic [4:0] bi_index;
  logic cond_bit;
  logic do_dec;
  logic [DATA_W-1:0] ctr_dec;
  logic ctr_ok;
  logic cond_ok;
  logic taken;
  logic form_bad;
  logic [DATA_W-1:0] target;

  bccl_bitsel u_bitsel (
    .bit_select(condition_bit_select),
    .field(bi_field),
    .bit_in_field(bi_bit),
    .arch_bit(bi_arch),
    .vec_index(bi_index)
  );

  always_comb
  begin
    cond_bit = cr_r[bi_index];
    form_bad = !branch_options_field[bccl_pkg::BO_NO_DEC] && (branch_kind == bccl_pkg::BCCL_BR_COUNT);
    do_dec = branch_valid && !branch_options_field[bccl_pkg::BO_NO_DEC] && !form_bad;
    ctr_dec = loop_count_r - bccl_pkg::COUNT_STEP;
    if (!branch_options_field[bccl_pkg::BO_NO_DEC])
    begin
      ctr_ok = (ctr_dec == bccl_pkg::ZERO_WORD) == branch_options_field[bccl_pkg::BO_CTR_ZERO];
    end
    else
    begin
      ctr_ok = 1'b1;
    end
    cond_ok = branch_options_field[bccl_pkg::BO_IGN_COND]
      || (cond_bit == branch_options_field[bccl_pkg::BO_COND_VAL]);
    taken = branch_valid && ctr_ok && cond_ok && !form_bad;
  end

  always_comb
  begin
    unique case (branch_kind)
      bccl_pkg::BCCL_BR_COUNT:
      begin
        target = loop_count_r;
      end
      bccl_pkg::BCCL_BR_LINK:
      begin
        target = link_r & bccl_pkg::WORD_ALIGN_MASK;
      end
      default:
      begin
        target = branch_rel_target;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // loop count and link registers, untouched by core reset
  // ----------------------------------------------------------------
  logic wr_count;
  logic wr_link;

  always_comb
  begin
    wr_count = spr_wr && (special_register_number == bccl_pkg::SPR_COUNT);
    wr_link = spr_wr && (special_register_number == bccl_pkg::SPR_LINK);
    loop_count_nxt = loop_count_r;
    if (do_dec)
    begin
      loop_count_nxt = ctr_dec;
    end
    if (wr_count)
    begin
      loop_count_nxt = spr_wdata;
    end
    link_nxt = link_r;
    if (branch_valid && branch_link && !form_bad)
    begin
      link_nxt = branch_return_addr;
    end
    if (wr_link)
    begin
      link_nxt = spr_wdata;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    loop_count_r <= loop_count_nxt;
  end

  always_ff @(posedge sys_clk)
  begin
    link_r <= link_nxt;
  end

  // ----------------------------------------------------------------
  // special register read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      spr_rdata_r <= '0;
      spr_rd_valid_r <= 1'b0;
      spr_rd_hit_r <= 1'b0;
    end
    else
    begin
      spr_rd_valid_r <= spr_rd;
      spr_rd_hit_r <= 1'b0;
      spr_rdata_r <= '0;
      if (spr_rd && (special_register_number == bccl_pkg::SPR_LINK))
      begin
        spr_rdata_r <= link_r;
        spr_rd_hit_r <= 1'b1;
      end
      else if (spr_rd && (special_register_number == bccl_pkg::SPR_COUNT))
      begin
        spr_rdata_r <= loop_count_r;
        spr_rd_hit_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // branch result outputs
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      branch_done_r <= 1'b0;
      branch_taken_r <= 1'b0;
      branch_target_r <= '0;
      branch_form_bad_r <= 1'b0;
      branch_arch_bit_r <= '0;
      branch_cond_bit_r <= 1'b0;
    end
    else
    begin
      branch_done_r <= branch_valid;
      branch_taken_r <= taken;
      branch_form_bad_r <= branch_valid && form_bad;
      if (branch_valid)
      begin
        branch_target_r <= target;
        branch_arch_bit_r <= bi_arch;
        branch_cond_bit_r <= cond_bit;
      end
    end
  end

  // ----------------------------------------------------------------
  // register views
  // ----------------------------------------------------------------
  assign condition_flags_reg = cr_r;
  assign loop_count = loop_count_r;
  assign return_link_address = link_r;

endmodule

`default_nettype wire

// [verif/bccl_regs_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// port checker
// ----
module bccl_regs_monitor #(
  parameter int unsigned DATA_W = 32
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic stcx_done,
  input wire logic cmp_valid,
  input wire logic [2:0] cmp_field,
  input wire logic branch_valid,
  input wire logic [4:0] condition_bit_select,
  input wire logic spr_wr,
  input wire logic spr_rd,
  input wire logic [9:0] special_register_number,
  input wire logic [DATA_W-1:0] spr_wdata,
  input wire logic [DATA_W-1:0] spr_rdata_r,
  input wire logic spr_rd_valid_r,
  input wire logic spr_rd_hit_r,
  input wire logic branch_done_r,
  input wire logic [5:0] branch_arch_bit_r,
  input wire logic [31:0] condition_flags_reg,
  input wire logic [DATA_W-1:0] loop_count,
  input wire logic [DATA_W-1:0] return_link_address
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  wire logic lr_sel = special_register_number == bccl_pkg::SPR_LINK;
  wire logic ct_sel = special_register_number == bccl_pkg::SPR_COUNT;
  sequence s_rd_ans;
    spr_rd_valid_r && spr_rd_hit_r;
  endsequence
  chk_rd_answer: assert property (spr_rd && (lr_sel || ct_sel) |=> s_rd_ans)
    else $error("read of mapped register not answered");
  chk_rd_link: assert property (spr_rd && lr_sel |=> spr_rdata_r == $past(return_link_address))
    else $error("link read data wrong");
  chk_rd_miss: assert property (spr_rd && special_register_number > 10'h9 |=> !spr_rd_hit_r && spr_rdata_r == 32'h0)
    else $error("unmapped read hit");
  chk_link_load: assert property (spr_wr && lr_sel |=> return_link_address == $past(spr_wdata))
    else $error("link write lost");
  chk_count_load: assert property (spr_wr && ct_sel |=> loop_count == $past(spr_wdata))
    else $error("count write lost");
  chk_br_done: assert property (branch_valid |=> branch_done_r)
    else $error("branch not completed");
  chk_arch_bit: assert property (branch_valid |=> branch_arch_bit_r == {1'b1, $past(condition_bit_select)})
    else $error("architectural bit number wrong");
  chk_cr_keep: assert property (cmp_valid && !stcx_done && cmp_field == 3'h7
    |=> condition_flags_reg[31:4] == $past(condition_flags_reg[31:4]))
    else $error("unselected field changed");
  chk_core_reset: assert property ($fell(rst) |-> return_link_address == $past(return_link_address, 3)
    && loop_count == $past(loop_count, 3))
    else $error("register lost across core reset");
endmodule
bind bccl_regs bccl_regs_monitor #(.DATA_W(DATA_W)) i_bccl_regs_monitor (.*);
`default_nettype wire

// [verif/bccl_core_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ----
// execute unit model
// ----
module bccl_core_model (
  output logic summary_overflow_flag,
  output logic stcx_done,
  output logic stcx_success,
  output logic cmp_valid,
  output logic [2:0] cmp_field,
  output logic cmp_signed,
  output logic cmp_use_imm,
  output logic [31:0] cmp_op_a,
  output logic [31:0] cmp_op_b,
  output logic [15:0] cmp_imm
);
  logic [86:0] req = '0;
  assign {cmp_field, cmp_signed, cmp_use_imm, cmp_op_a, cmp_op_b, cmp_imm, summary_overflow_flag, stcx_success} = req;
  initial
  begin
    stcx_done = 1'b0;
    cmp_valid = 1'b0;
  end
  task automatic put(input logic st, input logic [86:0] v);
    req = v;
    stcx_done = st;
    cmp_valid = !st;
  endtask
  // released operands show a changed pattern
  task automatic idle();
    req = ~req;
    stcx_done = 1'b0;
    cmp_valid = 1'b0;
  endtask
endmodule
`default_nettype wire

// [verif/branch_condition_count_link_regs_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module branch_condition_count_link_regs_tb;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic branch_valid = 1'b0;
  logic branch_link = 1'b0;
  logic spr_wr = 1'b0;
  logic spr_rd = 1'b0;
  bccl_pkg::bccl_br_kind_e kind = bccl_pkg::BCCL_BR_REL;
  logic [4:0] bo = 5'h0;
  logic [4:0] bi = 5'h0;
  logic [9:0] num = 10'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rel = 32'h0;
  logic [31:0] ret = 32'h0;
  logic [31:0] lfsr = 32'h6;
  logic sof, std, sts, cv, cs, cu, rvalid, hit, done, taken, cbit, st, lt, gt, eq, ok, bad, fb;
  logic [2:0] cf;
  logic [15:0] ci;
  logic [31:0] ca, cb, rdata, target, cr, ctr, lr, cr_m, ctr_m, lr_m, b, dec;
  logic [86:0] v;
  int mismatches = 0;
  int comparisons = 0;
  bccl_core_model i_bccl_core_model (
    .summary_overflow_flag(sof), .stcx_done(std), .stcx_success(sts), .cmp_valid(cv),
    .cmp_field(cf), .cmp_signed(cs), .cmp_use_imm(cu), .cmp_op_a(ca), .cmp_op_b(cb), .cmp_imm(ci)
  );
  bccl_regs i_bccl_regs (
    .sys_clk(sys_clk), .rst(rst), .summary_overflow_flag(sof), .stcx_done(std), .stcx_success(sts),
    .cmp_valid(cv), .cmp_field(cf), .cmp_signed(cs), .cmp_use_imm(cu), .cmp_op_a(ca), .cmp_op_b(cb),
    .cmp_imm(ci), .branch_valid(branch_valid), .branch_kind(kind), .branch_options_field(bo),
    .condition_bit_select(bi), .branch_link(branch_link), .branch_rel_target(rel),
    .branch_return_addr(ret), .spr_wr(spr_wr), .spr_rd(spr_rd), .special_register_number(num),
    .spr_wdata(wdata), .spr_rdata_r(rdata), .spr_rd_valid_r(rvalid), .spr_rd_hit_r(hit),
    .branch_done_r(done), .branch_taken_r(taken), .branch_target_r(target), .branch_form_bad_r(fb),
    .branch_arch_bit_r(), .branch_cond_bit_r(cbit), .condition_flags_reg(cr), .loop_count(ctr),
    .return_link_address(lr)
  );
  initial
    forever #2 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic spr_chk(input logic w, input logic [9:0] n, input logic [31:0] d);
    spr_wr = w;
    spr_rd = !w;
    num = n;
    wdata = d;
    step();
    check(rvalid, !w);
    if (!w)
    begin
      check(rdata, n == 10'h8 ? lr_m : n == 10'h9 ? ctr_m : 32'h0);
      check(hit, n[9:1] == 9'h4);
    end
    if (w && n == 10'h8)
      lr_m = d;
    if (w && n == 10'h9)
      ctr_m = d;
    check(lr, lr_m);
    check(ctr, ctr_m);
    spr_wr = 1'b0;
    spr_rd = 1'b0;
    wdata = ~d;
    step();
  endtask
  task automatic br(input bccl_pkg::bccl_br_kind_e k, input logic [4:0] o, input logic [4:0] s);
    dec = ctr_m - 32'h1;
    bad = (k == bccl_pkg::BCCL_BR_COUNT) && !o[2];
    ok = !bad && (o[4] || cr_m[31-s] == o[3]) && (o[2] || (dec == 32'h0) == o[1]);
    branch_valid = 1'b1;
    kind = k;
    bo = o;
    bi = s;
    branch_link = lfsr[3];
    rel = rnd();
    ret = rnd();
    step();
    check(taken, ok);
    check(done, 1'b1);
    check(fb, bad);
    check(cbit, cr_m[31-s]);
    if (ok && k == bccl_pkg::BCCL_BR_COUNT)
      check(target, ctr_m);
    if (ok && k == bccl_pkg::BCCL_BR_LINK)
      check(target, lr_m & bccl_pkg::WORD_ALIGN_MASK);
    if (!o[2] && !bad)
      ctr_m = dec;
    if (branch_link && !bad)
      lr_m = ret;
    check(ctr, ctr_m);
    check(lr, lr_m);
    branch_valid = 1'b0;
    rel = ~rel;
    ret = ~ret;
    step();
  endtask
  initial
  begin
    #50000;
    mismatches++;
    wrap_up();
  end
  initial
  begin
    repeat (2) step();
    spr_chk(1'b1, 10'h8, rnd());
    spr_chk(1'b1, 10'h9, 32'h0);
    repeat (14) step();
    rst = 1'b0;
    for (int n = 7; n < 11; n++)
    begin
      spr_chk(1'b1, 10'(n), rnd());
      spr_chk(1'b0, 10'(n), 32'h0);
    end
    $display("test registers done");
    for (int i = 0; i < 40; i++)
    begin
      v = 87'({rnd(), rnd(), rnd()});
      st = i > 7 && v[0] && v[2];
      if (i < 8)
        v[86:84] = 3'(i);
      if (i % 2 == 1)
        v[49:18] = v[81:50];
      b = !v[82] ? v[49:18] : v[83] ? {{16{v[17]}}, v[17:2]} : {16'h0, v[17:2]};
      lt = v[83] ? $signed(v[81:50]) < $signed(b) : v[81:50] < b;
      gt = v[83] ? $signed(v[81:50]) > $signed(b) : v[81:50] > b;
      eq = v[81:50] == b;
      i_bccl_core_model.put(st, v);
      step();
      if (st)
        cr_m[31:28] = {2'h0, v[0], v[1]};
      else
        cr_m[31-4*v[86:84] -: 4] = {lt, gt, eq, v[1]};
      check(cr, cr_m);
      i_bccl_core_model.idle();
      step();
    end
    $display("test compares done");
    spr_chk(1'b1, 10'h9, 32'h0);
    br(bccl_pkg::BCCL_BR_REL, 5'h10, 5'h0);
    check(ctr, 32'hFFFF_FFFF);
    br(bccl_pkg::BCCL_BR_COUNT, 5'h10, 5'h0);
    spr_chk(1'b1, 10'h9, 32'h2);
    for (int i = 0; i < 30; i++)
    begin
      v[31:0] = rnd();
      br(bccl_pkg::bccl_br_kind_e'(i % 3), v[4:0] | (i % 3 == 1 ? 5'h4 : 5'h0), v[9:5]);
    end
    $display("test branches done");
    rst = 1'b1;
    repeat (4) step();
    rst = 1'b0;
    step();
    check(lr, lr_m);
    check(ctr, ctr_m);
    $display("test core reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
